// File: core/emx_pkg.sv
// Shared constants and types of the expansion module supervisor.
package emx_pkg;
   // Clock and supervision tick timing.
   localparam int CLK_NS = 25;
   localparam int TICK_NS = 10_000_000;
   localparam int TICK_CYCLES = TICK_NS / CLK_NS;
   localparam int TIMEOUT_TICKS = 200;
   localparam int DUP_TICKS = 20;
   localparam int AGE_W = 8;
   // Module counts per family and channels per module.
   localparam int N_TEMP = 16;
   localparam int N_AIN = 16;
   localparam int N_AOUT = 8;
   localparam int N_DIN = 10;
   localparam int N_PROT = 2;
   localparam int N_PC = 2;
   localparam int CH_TEMP = 3;
   localparam int CH_AIN = 4;
   localparam int CH_AOUT = 4;
   localparam int DIN_BITS = 16;
   localparam int RELAY_GRP = 8;
   localparam int PC_W = 32;
   // Flat slot numbering of modules and measurement channels.
   localparam int BASE_TEMP = 0;
   localparam int BASE_AIN = BASE_TEMP + N_TEMP;
   localparam int BASE_AOUT = BASE_AIN + N_AIN;
   localparam int BASE_DIN = BASE_AOUT + N_AOUT;
   localparam int BASE_PROT = BASE_DIN + N_DIN;
   localparam int BASE_PC = BASE_PROT + N_PROT;
   localparam int N_MOD = BASE_PC + N_PC;
   localparam int N_TCH = N_TEMP * CH_TEMP;
   localparam int N_CH = N_TCH + N_AIN * CH_AIN;
   localparam int MW = $clog2(N_MOD);
   localparam int CW = $clog2(N_CH);
   // Value format: 100 percent is one shifted by PCT_SHIFT.
   localparam int DW = 16;
   localparam int PCT_SHIFT = 14;
   // Warning codes shown on the diagnostic port.
   localparam logic [7:0] W_NONE = 8'h00;
   localparam logic [7:0] W_BUSOFF = 8'hFB;
   localparam logic [7:0] W_MISSMOD = 8'hFC;
   localparam logic [7:0] W_MISSMEAS = 8'hFD;
   localparam logic [7:0] W_DUP = 8'hFE;
   localparam logic [7:0] W_SENSOR = 8'hFF;
   typedef enum logic [2:0] {
      MT_TEMP = 3'h0, MT_AIN = 3'h1, MT_AOUT = 3'h2,
      MT_DIN = 3'h3, MT_PROT = 3'h4, MT_PC = 3'h5
   } emx_mod_t;
   typedef enum logic [1:0] {
      FK_HBEAT = 2'h0, FK_MEAS = 2'h1, FK_COUNT = 2'h2, FK_DIN = 2'h3
   } emx_kind_t;
endpackage

// File: core/emx_curve_if.sv
// Request and answer signals between the supervisor and a curve unit.
`timescale 1ns/1ps
interface emx_curve_if;
   logic req;
   logic bypass;
   logic [emx_pkg::DW-1:0] pct;
   logic [emx_pkg::DW-1:0] lo;
   logic [emx_pkg::DW-1:0] hi;
   logic [emx_pkg::CW-1:0] tag;
   logic vld;
   logic [emx_pkg::DW-1:0] res;
   logic [emx_pkg::CW-1:0] tag_o;
   modport user(output req, bypass, pct, lo, hi, tag,
                input vld, res, tag_o);
   modport conv(input req, bypass, pct, lo, hi, tag,
                output vld, res, tag_o);
endinterface

// File: core/emx_curve.sv
// Linear conversion curve between percentages and real quantities.
`timescale 1ns/1ps
module emx_curve (
   input logic CLOCK,
   input logic RST,
   emx_curve_if.conv cv
);
   localparam int DW = emx_pkg::DW;
   localparam int SH = emx_pkg::PCT_SHIFT;
   logic signed [DW:0] span;
   logic signed [2*DW+1:0] prod;
   logic [DW-1:0] conv;
   logic vld_r, vld_nxt;
   logic [DW-1:0] res_r, res_nxt;
   logic [emx_pkg::CW-1:0] tag_r, tag_nxt;

   // Result is lo at 0 percent and hi at 100 percent; sign is kept.
   always_comb begin
      span = $signed({cv.hi[DW-1], cv.hi}) - $signed({cv.lo[DW-1], cv.lo});
      prod = span * $signed({1'h0, cv.pct});
      conv = DW'(cv.lo + prod[SH +: DW]);
      vld_nxt = cv.req;
      res_nxt = cv.bypass ? cv.pct : conv;
      tag_nxt = cv.tag;
   end

   // One cycle of latency keeps the answer on flip-flops.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         vld_r <= 1'h0;
         res_r <= '0;
         tag_r <= '0;
      end else begin
         vld_r <= vld_nxt;
         res_r <= res_nxt;
         tag_r <= tag_nxt;
      end
   end

   assign cv.vld = vld_r;
   assign cv.res = res_r;
   assign cv.tag_o = tag_r;
endmodule

// File: core/emx_supervisor.sv
// Supervisor of the expansion modules on the expansion CAN line.
`timescale 1ns/1ps
// Contract
// - Slots exist for 16 temperature, 16 analogue-in, 8 analogue-out, 10 digital, 2 protection and 2 counter modules.
// - Any configured slot may be used, with no need for contiguous addresses.
// - A configured module not heard from raises the missing-module warning 252.
// - A used analogue measure not received raises the missing-measure warning 253.
// - A used input reporting a disconnected sensor raises warning 255.
// - Bus-off on the expansion line raises warning 251.
// - Two modules using one address raise the duplicated-address warning 254.
// - Every warning comes with the module address and measure index concerned; the code reports them for the highest-priority warning only.
// - Analogue-out commands go out as percentages, optionally through a curve.
// - Analogue-in percentages are turned into real values by a curve.
// - A module configured as present enables its extra configuration entries.
// - Counter modules broadcast counts that are taken with no configuration.
// - A digital module has 16 inputs and 0, 8 or 16 relay outputs.
// - Each analogue-in module provides 4 measurement channels.
module emx_supervisor #(
   parameter int TICK_CYCLES = emx_pkg::TICK_CYCLES,
   parameter int TIMEOUT_TICKS = emx_pkg::TIMEOUT_TICKS,
   parameter int DUP_TICKS = emx_pkg::DUP_TICKS
) (
   input logic CLOCK,
   input logic RST,
   input logic RX_VALID,
   input logic [1:0] RX_KIND,
   input logic [2:0] RX_TYPE,
   input logic [3:0] RX_ADDR,
   input logic [1:0] RX_CHAN,
   input logic [31:0] RX_DATA,
   input logic RX_FAULT,
   input logic BUS_OFF,
   input logic [emx_pkg::N_MOD-1:0] CFG_PRESENT,
   input logic [emx_pkg::N_CH-1:0] CFG_USED,
   input logic [2*emx_pkg::N_DIN-1:0] CFG_RELAYS,
   input logic AIN_CURVE_EN,
   input logic [emx_pkg::DW-1:0] AIN_LO,
   input logic [emx_pkg::DW-1:0] AIN_HI,
   input logic AO_VALID,
   input logic [2:0] AO_ADDR,
   input logic [1:0] AO_CHAN,
   input logic [emx_pkg::DW-1:0] AO_VALUE,
   input logic AO_CURVE_EN,
   input logic [emx_pkg::DW-1:0] AO_LO,
   input logic [emx_pkg::DW-1:0] AO_HI,
   input logic [emx_pkg::N_DIN*emx_pkg::DIN_BITS-1:0] DO_CMD,
   output logic TX_VALID,
   output logic [2:0] TX_ADDR,
   output logic [1:0] TX_CHAN,
   output logic [emx_pkg::DW-1:0] TX_DATA,
   output logic MEAS_VALID,
   output logic [emx_pkg::CW-1:0] MEAS_INDEX,
   output logic [emx_pkg::DW-1:0] MEAS_VALUE,
   output logic [emx_pkg::N_DIN*emx_pkg::DIN_BITS-1:0] DIN_STATE,
   output logic [emx_pkg::N_DIN*emx_pkg::DIN_BITS-1:0] RELAY_OUT,
   output logic [emx_pkg::N_PC*emx_pkg::PC_W-1:0] PC_COUNT,
   output logic [emx_pkg::N_MOD-1:0] MENU_MOD,
   output logic [emx_pkg::N_CH-1:0] MENU_CH,
   output logic BUS_OFF_WARNING,
   output logic MISSING_MODULE_WARNING,
   output logic MISSING_MEASURE_WARNING,
   output logic DUPLICATE_ADDRESS_WARNING,
   output logic SENSOR_DISCONNECTED_WARNING,
   output logic [7:0] DIAG_CODE,
   output logic [2:0] DIAG_TYPE,
   output logic [3:0] DIAG_ADDR,
   output logic [1:0] DIAG_CHAN
);
   localparam int NM = emx_pkg::N_MOD;
   localparam int NC = emx_pkg::N_CH;
   localparam int MW = emx_pkg::MW;
   localparam int CW = emx_pkg::CW;
   localparam int AW = emx_pkg::AGE_W;
   localparam int TW = $clog2(TICK_CYCLES);
   localparam int DB = emx_pkg::DIN_BITS;
   localparam int RG = emx_pkg::RELAY_GRP;

   logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
   logic tick;
   int base, cnt, nch, cbase;
   logic rx_mod_ok, rx_ch_ok, rx_hb, rx_meas;
   logic [MW-1:0] rx_mod;
   logic [CW-1:0] rx_ch;
   wire [NM-1:0] mod_to, mod_dup;
   wire [NC-1:0] ch_to, ch_fault, ch_pres;
   logic [NC-1:0] v_dup, v_mod, v_meas, v_sens;
   logic [4:0] warn_r, warn_nxt;
   logic [7:0] code_r, code_nxt;
   logic [8:0] dloc_r, dloc_nxt;
   logic [NM-1:0] menu_mod_r, menu_mod_nxt;
   logic [NC-1:0] menu_ch_r, menu_ch_nxt;

   // Lowest set bit of a vector, with a found flag on top.
   function automatic logic [CW:0] first_one(input logic [NC-1:0] v);
      logic [CW:0] r;
      r = '0;
      for (int k = NC - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = {1'h1, CW'(k)};
         end
      end
      return r;
   endfunction

   // Module slot to family, address and a zero channel.
   function automatic logic [8:0] mod_loc(input logic [CW-1:0] m);
      int b;
      logic [2:0] t;
      b = emx_pkg::BASE_PC;
      t = emx_pkg::MT_PC;
      if (m < CW'(emx_pkg::BASE_AIN)) begin
         b = emx_pkg::BASE_TEMP; t = emx_pkg::MT_TEMP;
      end else if (m < CW'(emx_pkg::BASE_AOUT)) begin
         b = emx_pkg::BASE_AIN; t = emx_pkg::MT_AIN;
      end else if (m < CW'(emx_pkg::BASE_DIN)) begin
         b = emx_pkg::BASE_AOUT; t = emx_pkg::MT_AOUT;
      end else if (m < CW'(emx_pkg::BASE_PROT)) begin
         b = emx_pkg::BASE_DIN; t = emx_pkg::MT_DIN;
      end else if (m < CW'(emx_pkg::BASE_PC)) begin
         b = emx_pkg::BASE_PROT; t = emx_pkg::MT_PROT;
      end
      return {t, 4'(int'(m) - b), 2'h0};
   endfunction

   // Channel slot to family, module address and channel number.
   function automatic logic [8:0] ch_loc(input logic [CW-1:0] c);
      int i;
      i = int'(c);
      if (i < emx_pkg::N_TCH) begin
         return {emx_pkg::MT_TEMP, 4'(i / emx_pkg::CH_TEMP),
                 2'(i % emx_pkg::CH_TEMP)};
      end
      i = i - emx_pkg::N_TCH;
      return {emx_pkg::MT_AIN, 4'(i / emx_pkg::CH_AIN),
              2'(i % emx_pkg::CH_AIN)};
   endfunction

   // Supervision tick divider; ages count in ticks, not clock cycles.
   always_comb begin
      tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));
      tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'h1;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   // Frame decode into flat slots, so addresses may be sparse.
   always_comb begin
      base = 0;
      cnt = 0;
      nch = 0;
      cbase = 0;
      unique case (RX_TYPE)
         emx_pkg::MT_TEMP: begin
            base = emx_pkg::BASE_TEMP; cnt = emx_pkg::N_TEMP;
            nch = emx_pkg::CH_TEMP;
         end
         emx_pkg::MT_AIN: begin
            base = emx_pkg::BASE_AIN; cnt = emx_pkg::N_AIN;
            nch = emx_pkg::CH_AIN; cbase = emx_pkg::N_TCH;
         end
         emx_pkg::MT_AOUT: begin
            base = emx_pkg::BASE_AOUT; cnt = emx_pkg::N_AOUT;
         end
         emx_pkg::MT_DIN: begin
            base = emx_pkg::BASE_DIN; cnt = emx_pkg::N_DIN;
         end
         emx_pkg::MT_PROT: begin
            base = emx_pkg::BASE_PROT; cnt = emx_pkg::N_PROT;
         end
         emx_pkg::MT_PC: begin
            base = emx_pkg::BASE_PC; cnt = emx_pkg::N_PC;
         end
         default: ; // Unused family codes are dropped.
      endcase
      rx_mod_ok = RX_VALID && (int'(RX_ADDR) < cnt);
      rx_mod = MW'(base + int'(RX_ADDR));
      rx_hb = rx_mod_ok && (RX_KIND == emx_pkg::FK_HBEAT);
      rx_meas = rx_mod_ok && (RX_KIND == emx_pkg::FK_MEAS);
      rx_ch_ok = rx_meas && (int'(RX_CHAN) < nch);
      rx_ch = CW'(cbase + int'(RX_ADDR) * nch + int'(RX_CHAN));
   end

   // Per module: any frame proves presence, heartbeat gaps expose twins.
   for (genvar i = 0; i < NM; i++) begin : g_mod
      logic [AW-1:0] age_r, age_nxt, gap_r, gap_nxt;
      logic hb_seen_r, hb_seen_nxt, dup_r, dup_nxt, hit;
      always_comb begin
         hit = rx_mod_ok && (rx_mod == MW'(i));
         age_nxt = age_r;
         if (hit) begin
            age_nxt = '0;
         end else if (tick && !mod_to[i]) begin
            age_nxt = age_r + 1'h1;
         end
         gap_nxt = gap_r;
         if (hit && rx_hb) begin
            gap_nxt = '0;
         end else if (tick && gap_r < AW'(DUP_TICKS)) begin
            gap_nxt = gap_r + 1'h1;
         end
         hb_seen_nxt = (hit && rx_hb) | (hb_seen_r & !mod_to[i]);
         dup_nxt = (hit && rx_hb && hb_seen_r && gap_r < AW'(DUP_TICKS))
                   | (dup_r & !mod_to[i]);
      end
      always_ff @(posedge CLOCK) begin
         if (RST) begin
            age_r <= '0;
            gap_r <= '0;
            hb_seen_r <= 1'h0;
            dup_r <= 1'h0;
         end else begin
            age_r <= age_nxt;
            gap_r <= gap_nxt;
            hb_seen_r <= hb_seen_nxt;
            dup_r <= dup_nxt;
         end
      end
      assign mod_to[i] = (age_r >= AW'(TIMEOUT_TICKS));
      assign mod_dup[i] = dup_r;
      // Every slot is checked, so sparse addresses are covered too.
      AST_DUP: assert property (@(posedge CLOCK) disable iff (RST)
         hit && rx_hb && hb_seen_r && gap_r < AW'(DUP_TICKS)
         |=> ##1 DUPLICATE_ADDRESS_WARNING)
         else $error("duplicate address not reported");
   end

   // Per channel: age since last measure and the sensor fault flag.
   for (genvar j = 0; j < NC; j++) begin : g_ch
      localparam int PM = (j < emx_pkg::N_TCH)
         ? emx_pkg::BASE_TEMP + j / emx_pkg::CH_TEMP
         : emx_pkg::BASE_AIN + (j - emx_pkg::N_TCH) / emx_pkg::CH_AIN;
      logic [AW-1:0] age_r, age_nxt;
      logic flt_r, flt_nxt, hit;
      always_comb begin
         hit = rx_ch_ok && (rx_ch == CW'(j));
         age_nxt = age_r;
         if (hit) begin
            age_nxt = '0;
         end else if (tick && !ch_to[j]) begin
            age_nxt = age_r + 1'h1;
         end
         flt_nxt = hit ? RX_FAULT : (flt_r & !ch_to[j]);
      end
      always_ff @(posedge CLOCK) begin
         if (RST) begin
            age_r <= '0;
            flt_r <= 1'h0;
         end else begin
            age_r <= age_nxt;
            flt_r <= flt_nxt;
         end
      end
      assign ch_to[j] = (age_r >= AW'(TIMEOUT_TICKS));
      assign ch_fault[j] = flt_r;
      assign ch_pres[j] = CFG_PRESENT[PM];
      // A fault on a used channel must reach the warning two cycles on.
      AST_SENSOR: assert property (@(posedge CLOCK) disable iff (RST)
         hit && RX_FAULT && CFG_USED[j] && ch_pres[j]
         ##1 CFG_USED[j] && ch_pres[j] |=> SENSOR_DISCONNECTED_WARNING)
         else $error("sensor fault not reported");
   end

   // Warnings and diagnostics; bus-off first, then twins, then losses.
   always_comb begin
      logic [CW:0] f;
      f = '0;
      v_dup = NC'(mod_dup);
      v_mod = NC'(CFG_PRESENT & mod_to);
      v_meas = CFG_USED & ch_pres & ch_to;
      v_sens = CFG_USED & ch_pres & ch_fault;
      warn_nxt = {|v_sens, |v_dup, |v_meas, |v_mod, BUS_OFF};
      code_nxt = emx_pkg::W_NONE;
      dloc_nxt = '0;
      if (BUS_OFF) begin
         code_nxt = emx_pkg::W_BUSOFF;
      end else if (|v_dup) begin
         f = first_one(v_dup);
         code_nxt = emx_pkg::W_DUP;
         dloc_nxt = mod_loc(f[CW-1:0]);
      end else if (|v_mod) begin
         f = first_one(v_mod);
         code_nxt = emx_pkg::W_MISSMOD;
         dloc_nxt = mod_loc(f[CW-1:0]);
      end else if (|v_meas) begin
         f = first_one(v_meas);
         code_nxt = emx_pkg::W_MISSMEAS;
         dloc_nxt = ch_loc(f[CW-1:0]);
      end else if (|v_sens) begin
         f = first_one(v_sens);
         code_nxt = emx_pkg::W_SENSOR;
         dloc_nxt = ch_loc(f[CW-1:0]);
      end
      menu_mod_nxt = CFG_PRESENT;
      menu_ch_nxt = ch_pres;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         warn_r <= '0;
         code_r <= emx_pkg::W_NONE;
         dloc_r <= '0;
         menu_mod_r <= '0;
         menu_ch_r <= '0;
      end else begin
         warn_r <= warn_nxt;
         code_r <= code_nxt;
         dloc_r <= dloc_nxt;
         menu_mod_r <= menu_mod_nxt;
         menu_ch_r <= menu_ch_nxt;
      end
   end

   assign {SENSOR_DISCONNECTED_WARNING, DUPLICATE_ADDRESS_WARNING,
           MISSING_MEASURE_WARNING, MISSING_MODULE_WARNING,
           BUS_OFF_WARNING} = warn_r;
   assign DIAG_CODE = code_r;
   assign {DIAG_TYPE, DIAG_ADDR, DIAG_CHAN} = dloc_r;
   assign MENU_MOD = menu_mod_r;
   assign MENU_CH = menu_ch_r;

   // Digital inputs, relay groups and broadcast counters.
   for (genvar k = 0; k < emx_pkg::N_DIN; k++) begin : g_din
      logic [DB-1:0] din_r, din_nxt, rly_r, rly_nxt;
      always_comb begin
         din_nxt = din_r;
         if (rx_mod_ok && RX_KIND == emx_pkg::FK_DIN &&
             rx_mod == MW'(emx_pkg::BASE_DIN + k)) begin
            din_nxt = RX_DATA[DB-1:0];
         end
         rly_nxt = DO_CMD[k*DB +: DB];
         if (CFG_RELAYS[2*k +: 2] == 2'h0) begin
            rly_nxt = '0;
         end else if (CFG_RELAYS[2*k +: 2] == 2'h1) begin
            rly_nxt[DB-1:RG] = '0;
         end
      end
      always_ff @(posedge CLOCK) begin
         if (RST) begin
            din_r <= '0;
            rly_r <= '0;
         end else begin
            din_r <= din_nxt;
            rly_r <= rly_nxt;
         end
      end
      assign DIN_STATE[k*DB +: DB] = din_r;
      assign RELAY_OUT[k*DB +: DB] = rly_r;
   end

   for (genvar p = 0; p < emx_pkg::N_PC; p++) begin : g_pc
      logic [emx_pkg::PC_W-1:0] cnt_r, cnt_nxt;
      always_comb begin
         cnt_nxt = cnt_r;
         if (rx_mod_ok && RX_KIND == emx_pkg::FK_COUNT &&
             rx_mod == MW'(emx_pkg::BASE_PC + p)) begin
            cnt_nxt = RX_DATA;
         end
      end
      always_ff @(posedge CLOCK) begin
         if (RST) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_nxt;
         end
      end
      assign PC_COUNT[p*emx_pkg::PC_W +: emx_pkg::PC_W] = cnt_r;
   end

   // Measures pass a curve; temperatures bypass it to keep one latency.
   emx_curve_if cv_in ();
   emx_curve_if cv_out ();
   assign cv_in.req = rx_ch_ok;
   assign cv_in.bypass = (RX_TYPE == emx_pkg::MT_TEMP) || !AIN_CURVE_EN;
   assign cv_in.pct = RX_DATA[emx_pkg::DW-1:0];
   assign cv_in.lo = AIN_LO;
   assign cv_in.hi = AIN_HI;
   assign cv_in.tag = rx_ch;
   assign MEAS_VALID = cv_in.vld;
   assign MEAS_VALUE = cv_in.res;
   assign MEAS_INDEX = cv_in.tag_o;

   assign cv_out.req = AO_VALID;
   assign cv_out.bypass = !AO_CURVE_EN;
   assign cv_out.pct = AO_VALUE;
   assign cv_out.lo = AO_LO;
   assign cv_out.hi = AO_HI;
   assign cv_out.tag = CW'({AO_ADDR, AO_CHAN});
   assign TX_VALID = cv_out.vld;
   assign TX_DATA = cv_out.res;
   assign {TX_ADDR, TX_CHAN} = cv_out.tag_o[4:0];

   emx_curve u_cv_in (.CLOCK(CLOCK), .RST(RST), .cv(cv_in.conv));
   emx_curve u_cv_out (.CLOCK(CLOCK), .RST(RST), .cv(cv_out.conv));

   // Checks on the warning, timing and data paths.
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   AST_BUS_OFF: assert property (
      BUS_OFF |=> BUS_OFF_WARNING && DIAG_CODE == emx_pkg::W_BUSOFF)
      else $error("bus-off not reported");
   AST_MOD_MISSING: assert property (
      |(CFG_PRESENT & mod_to) |=> MISSING_MODULE_WARNING)
      else $error("missing module not reported");
   AST_MOD_TIMEOUT: assert property (
      $rose(mod_to[0]) |-> $past(tick) &&
      $past(g_mod[0].age_r) == AW'(TIMEOUT_TICKS - 1))
      else $error("module timeout at wrong age");
   AST_MEAS_MISSING: assert property (
      |(CFG_USED & ch_pres & ch_to) |=> MISSING_MEASURE_WARNING)
      else $error("missing measure not reported");
   AST_DIAG: assert property (
      MISSING_MODULE_WARNING && !BUS_OFF_WARNING &&
      !DUPLICATE_ADDRESS_WARNING |-> DIAG_CODE == emx_pkg::W_MISSMOD)
      else $error("diagnostic code mismatch");
   AST_AO_TX: assert property (
      AO_VALID && !AO_CURVE_EN |=> TX_VALID && TX_DATA == $past(AO_VALUE))
      else $error("output command not sent as percent");
   AST_TEMP: assert property (
      rx_ch_ok && RX_TYPE == emx_pkg::MT_TEMP |=>
      MEAS_VALID && MEAS_VALUE == $past(RX_DATA[emx_pkg::DW-1:0]))
      else $error("temperature was converted");
   AST_PC: assert property (
      rx_mod_ok && RX_KIND == emx_pkg::FK_COUNT &&
      RX_TYPE == emx_pkg::MT_PC |=>
      PC_COUNT[int'($past(RX_ADDR[0])) * emx_pkg::PC_W +: emx_pkg::PC_W]
      == $past(RX_DATA))
      else $error("counter value not taken");
   AST_RELAY: assert property (
      CFG_RELAYS[1:0] == 2'h1 |=> RELAY_OUT[DB-1:RG] == '0 &&
      RELAY_OUT[RG-1:0] == $past(DO_CMD[RG-1:0]))
      else $error("relay group mask wrong");
   AST_AIN_CH: assert property (
      rx_ch_ok && RX_TYPE == emx_pkg::MT_AIN && RX_ADDR == 4'h1 &&
      RX_CHAN == 2'h3 |=>
      MEAS_INDEX == CW'(emx_pkg::N_TCH + 2 * emx_pkg::CH_AIN - 1))
      else $error("analogue channel index wrong");

   COV_DUP: cover property (DUPLICATE_ADDRESS_WARNING);
   COV_MISS: cover property ($rose(MISSING_MODULE_WARNING));
   COV_SENS: cover property (SENSOR_DISCONNECTED_WARNING);
   COV_TX: cover property (AO_VALID && AO_CURVE_EN ##1 TX_VALID);
endmodule

// File: tb/emx_modules.sv
// Behavioural model of the expansion modules sending frames.
`timescale 1ns/1ps
module emx_modules (
   clk,
   rx_valid,
   rx_kind,
   rx_type,
   rx_addr,
   rx_chan,
   rx_data,
   rx_fault
);
   input wire logic clk;
   output logic rx_valid;
   output logic [1:0] rx_kind;
   output logic [2:0] rx_type;
   output logic [3:0] rx_addr;
   output logic [1:0] rx_chan;
   output logic [31:0] rx_data;
   output logic rx_fault;
   // Lines are quiet until the first frame is sent.
   initial begin
      {rx_valid, rx_kind, rx_type, rx_addr, rx_chan, rx_data} = '0;
      rx_fault = 1'b0;
   end
   // Broadcast one frame.
   // Data is inverted afterwards so a stale payload is never reused.
   task send(input logic [1:0] k, input logic [2:0] t,
             input logic [3:0] a, input logic [1:0] c,
             input logic [31:0] d, input logic f);
      @(negedge clk);
      {rx_kind, rx_type, rx_addr, rx_chan, rx_data} = {k, t, a, c, d};
      rx_fault = f;
      rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~d;
   endtask
endmodule

// File: tb/emx_supervisor_tb.sv
// Self-checking bench of the expansion module supervisor.
`timescale 1ns/1ps
module emx_supervisor_tb;
   logic clk, rst, bo, ai_en, ao_v, ao_en, rv, rf, tv, mv, w_bo, w_mm;
   logic w_ms, w_dup, w_sd;
   logic [1:0] rk, rc, ao_c, tc, dchan;
   logic [2:0] rt, ao_a, ta, dtype;
   logic [3:0] ra, daddr;
   logic [31:0] rd, v;
   logic [emx_pkg::N_MOD-1:0] cp, mm;
   logic [emx_pkg::N_CH-1:0] cu, mc;
   logic [19:0] cr;
   logic [15:0] ai_lo, ai_hi, ao_lo, ao_hi, ao_val, td, mval, msk;
   logic [159:0] doc, dst, rly;
   logic [63:0] pc;
   logic [emx_pkg::CW-1:0] midx;
   logic [7:0] dcode;
   int n_fail, checked, i;
   emx_modules pm (.clk(clk), .rx_valid(rv), .rx_kind(rk), .rx_type(rt),
      .rx_addr(ra), .rx_chan(rc), .rx_data(rd), .rx_fault(rf));
   emx_supervisor #(.TICK_CYCLES(4), .TIMEOUT_TICKS(5), .DUP_TICKS(3)) uut (
      .CLOCK(clk), .RST(rst), .RX_VALID(rv), .RX_KIND(rk), .RX_TYPE(rt),
      .RX_ADDR(ra), .RX_CHAN(rc), .RX_DATA(rd), .RX_FAULT(rf),
      .BUS_OFF(bo), .CFG_PRESENT(cp), .CFG_USED(cu), .CFG_RELAYS(cr),
      .AIN_CURVE_EN(ai_en), .AIN_LO(ai_lo), .AIN_HI(ai_hi),
      .AO_VALID(ao_v), .AO_ADDR(ao_a), .AO_CHAN(ao_c), .AO_VALUE(ao_val),
      .AO_CURVE_EN(ao_en), .AO_LO(ao_lo), .AO_HI(ao_hi), .DO_CMD(doc),
      .TX_VALID(tv), .TX_ADDR(ta), .TX_CHAN(tc), .TX_DATA(td),
      .MEAS_VALID(mv), .MEAS_INDEX(midx), .MEAS_VALUE(mval),
      .DIN_STATE(dst), .RELAY_OUT(rly), .PC_COUNT(pc), .MENU_MOD(mm),
      .MENU_CH(mc), .BUS_OFF_WARNING(w_bo), .MISSING_MODULE_WARNING(w_mm),
      .MISSING_MEASURE_WARNING(w_ms), .DUPLICATE_ADDRESS_WARNING(w_dup),
      .SENSOR_DISCONNECTED_WARNING(w_sd), .DIAG_CODE(dcode),
      .DIAG_TYPE(dtype), .DIAG_ADDR(daddr), .DIAG_CHAN(dchan));
   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Expected curve output, widened so the product cannot overflow.
   function logic [15:0] curve(input logic [15:0] lo, hi, p);
      logic [31:0] t;
      t = 32'(hi - lo) * 32'(p);
      return lo + 16'(t >> 14);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog at 2000 cycles, far beyond the hundred or so cycles the tests need.
   initial begin
      #50000;
      n_fail++;
      test_done;
   end
   // Main sequence; a waiting loop gives up after 60 cycles.
   initial begin
      n_fail = 0;
      checked = 0;
      {bo, ai_en, ao_v, ao_en, ao_a, ao_c, cu, cr, doc} = '0;
      {ai_lo, ao_lo, ao_val} = '0;
      ai_hi = 16'h03E8;
      ao_hi = 16'h07D0;
      cp = '0;
      cp[43] = 1'b1;
      v = $urandom(12925);
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      chk(dcode, 32'h0);
      repeat (2) @(negedge clk);
      chk(mm, cp);
      chk(w_mm, 32'h0);
      for (i = 0; i < 60 && w_mm !== 1'b1; i++) @(negedge clk);
      chk({dcode, 1'b0, dtype, daddr}, 32'hFC33);
      pm.send(2'h0, 3'h3, 4'h3, 2'h0, 32'h0, 1'b0);
      repeat (2) @(negedge clk);
      chk(w_mm, 32'h0);
      cp = '0;
      for (i = 0; i < 2; i++) begin
         ai_en = i[0];
         pm.send(2'h1, 3'h1, 4'h1, 2'h3, 32'h2000, 1'b0);
         chk({mv, 1'(0), midx}, 32'h137);
         chk(mval, i ? curve(ai_lo, ai_hi, 16'h2000) : 16'h2000);
      end
      // Curve stays on: a temperature must still pass unconverted.
      pm.send(2'h1, 3'h0, 4'h2, 2'h1, 32'h1234, 1'b0);
      chk({mv, midx, mval}, 32'h871234);
      cu[55] = 1'b1;
      cp[17] = 1'b1;
      pm.send(2'h1, 3'h1, 4'h1, 2'h3, 32'h1000, 1'b1);
      repeat (2) @(negedge clk);
      chk(w_sd, 32'h1);
      chk({dcode, 1'b0, dtype, daddr, 2'h0, dchan}, 32'hFF113);
      chk(mc[63:48], 32'h00F0);
      // Frames on channel 52 keep the module alive while 55 ages out.
      for (i = 0; i < 30 && w_ms !== 1'b1; i++) begin
         pm.send(2'h1, 3'h1, 4'h1, 2'h0, 32'h0, 1'b0);
      end
      chk({dcode, dchan}, 32'h3F7);
      bo = 1'b1;
      @(negedge clk);
      chk({w_bo, dcode}, 32'h1FB);
      bo = 1'b0;
      pm.send(2'h0, 3'h0, 4'h2, 2'h0, 32'h0, 1'b0);
      pm.send(2'h0, 3'h0, 4'h2, 2'h0, 32'h0, 1'b0);
      repeat (2) @(negedge clk);
      chk({w_dup, dcode, 1'b0, dtype, daddr}, 32'h1FE02);
      for (i = 0; i < 4; i++) begin
         ao_val = 16'($urandom_range(16384));
         {ao_a, ao_c} = 5'($urandom);
         ao_en = i[0];
         ao_v = 1'b1;
         @(negedge clk);
         ao_v = 1'b0;
         chk({tv, ta, tc}, {26'h0, 1'b1, ao_a, ao_c});
         chk(td, ao_en ? curve(ao_lo, ao_hi, ao_val) : ao_val);
         cr[1:0] = 2'(i);
         doc = {5{$urandom}};
         repeat (2) @(negedge clk);
         msk = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00FF : 16'hFFFF;
         chk(rly[15:0], doc[15:0] & msk);
      end
      v = $urandom;
      pm.send(2'h2, 3'h5, 4'h1, 2'h0, v, 1'b0);
      chk(pc[63:32], v);
      pm.send(2'h3, 3'h3, 4'h9, 2'h0, v, 1'b0);
      chk(dst[159:144], v[15:0]);
      test_done;
   end
endmodule
